// File: logic/sfks_map.vh
`ifndef SFKS_MAP_VH
`define SFKS_MAP_VH

// Command codes on cmd_op
`define SFKS_OP_ENROLL      3'h1
`define SFKS_OP_START       3'h2
`define SFKS_OP_WRAP        3'h3
`define SFKS_OP_GEN         3'h4
`define SFKS_OP_UNWRAP      3'h5

// Key length in 64-bit units: 64 bits up to 4096 bits
`define SFKS_LEN_MIN        7'h01
`define SFKS_LEN_MAX        7'h40

// Root key and helper data: eight 32-bit words, 256 bits
`define SFKS_ROOT_LAST      8'h07

// Key code header word layout
`define SFKS_HDR_IDX_LSB    0
`define SFKS_HDR_LEN_LSB    4
`define SFKS_HDR_RSVD_LSB   11

// Reset values
`define SFKS_RST_WORD       32'h00000000
`define SFKS_RST_CNT        8'h00
`define SFKS_RST_IDX        4'h0
`define SFKS_RST_LEN        7'h00

`endif

// File: logic/sfks_core.v
// What this block does
// - Wrap supplied or internally generated keys of 64 to 4096 bits.
// - Host gives a 4-bit index per key; it travels in the code header.
// - Codes whose header index is zero unwrap only to the hardware key bus; the index is not mixed into the code.
// - Non-zero index keys are readable on the register data port.
// - Root key of 256 bits comes from fingerprint combined with helper data.
// - Key code is key mixed with fingerprint root; plain key is never held.
// - Enrollment emits helper data; host stores it for root rebuild.
// - No other path exposes key values; idle key outputs read zero.
`include "sfks_map.vh"

module sfks_core (
	input  wire         sys_clk,
	input  wire         arst_n,
	input  wire [255:0] sram_fingerprint,
	input  wire [31:0]  entropy_word,
	input  wire         cmd_valid,
	input  wire [2:0]   cmd_op,
	input  wire [3:0]   cmd_index,
	input  wire [6:0]   cmd_len,
	output wire         cmd_ready,
	output reg          cmd_error,
	output reg          root_valid,
	input  wire         din_valid,
	input  wire [31:0]  din_data,
	output wire         din_ready,
	output reg          dout_valid,
	output reg  [31:0]  dout_data,
	input  wire         dout_ready,
	output reg          hwkey_valid,
	output reg  [31:0]  hwkey_data,
	output reg          hwkey_last
);

	localparam [2:0] ST_IDLE     = 3'h0;
	localparam [2:0] ST_HELP_OUT = 3'h1;
	localparam [2:0] ST_HELP_IN  = 3'h2;
	localparam [2:0] ST_HDR_OUT  = 3'h3;
	localparam [2:0] ST_WRAP     = 3'h4;
	localparam [2:0] ST_UNW_HDR  = 3'h5;
	localparam [2:0] ST_UNWRAP   = 3'h6;

	reg  [2:0]  state;
	reg  [7:0]  cnt;
	reg  [3:0]  cur_idx;
	reg  [6:0]  cur_len;
	reg         cur_gen;
	reg  [31:0] root_mem [0:7];
	wire [31:0] fp_word;
	wire [31:0] mix_word;
	wire [7:0]  last_cnt;
	wire        out_free;
	wire        len_ok;
	wire        hdr_len_ok;
	wire [31:0] wrap_src;
	wire        wrap_have;
	integer     i;

	////////////////////////////////////////////////////////////////
	// Datapath helpers
	assign fp_word    = sram_fingerprint[{cnt[2:0], 5'h00} +: 32];
	// Keystream from root key and word position, so repeated words differ
	assign mix_word   = root_mem[cnt[2:0]] ^ {24'h000000, cnt};
	assign last_cnt   = {cur_len - 7'h01, 1'b1};
	assign out_free   = !dout_valid || dout_ready;
	assign len_ok     = (cmd_len >= `SFKS_LEN_MIN) && (cmd_len <= `SFKS_LEN_MAX);
	assign hdr_len_ok = (din_data[`SFKS_HDR_LEN_LSB +: 7] >= `SFKS_LEN_MIN) &&
	                    (din_data[`SFKS_HDR_LEN_LSB +: 7] <= `SFKS_LEN_MAX);
	assign wrap_src   = cur_gen ? entropy_word : din_data;
	assign wrap_have  = cur_gen || din_valid;
	assign cmd_ready  = (state == ST_IDLE);

	// Index-zero keys never wait on software while unwrapping, the key bus has no stall
	assign din_ready  = (state == ST_HELP_IN) ||
	                    (state == ST_UNW_HDR) ||
	                    (state == ST_WRAP && !cur_gen && out_free) ||
	                    (state == ST_UNWRAP && (cur_idx == 4'h0 || out_free));

	////////////////////////////////////////////////////////////////
	// Control and data registers
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state       <= ST_IDLE;
			cnt         <= `SFKS_RST_CNT;
			cur_idx     <= `SFKS_RST_IDX;
			cur_len     <= `SFKS_RST_LEN;
			cur_gen     <= 1'b0;
			cmd_error   <= 1'b0;
			root_valid  <= 1'b0;
			dout_valid  <= 1'b0;
			dout_data   <= `SFKS_RST_WORD;
			hwkey_valid <= 1'b0;
			hwkey_data  <= `SFKS_RST_WORD;
			hwkey_last  <= 1'b0;
			for (i = 0; i < 8; i = i + 1) begin
				root_mem[i] <= `SFKS_RST_WORD;
			end
		end else begin
			cmd_error   <= 1'b0;
			hwkey_valid <= 1'b0;
			hwkey_last  <= 1'b0;
			hwkey_data  <= `SFKS_RST_WORD;
			// Consumed words are wiped so no key lingers on the port
			if (dout_valid && dout_ready) begin
				dout_valid <= 1'b0;
				dout_data  <= `SFKS_RST_WORD;
			end
			case (state)
				ST_IDLE: begin
					cnt <= `SFKS_RST_CNT;
					if (cmd_valid) begin
						case (cmd_op)
							`SFKS_OP_ENROLL: begin
								root_valid <= 1'b0;
								state      <= ST_HELP_OUT;
							end
							`SFKS_OP_START: begin
								root_valid <= 1'b0;
								state      <= ST_HELP_IN;
							end
							`SFKS_OP_WRAP, `SFKS_OP_GEN: begin
								if (root_valid && len_ok) begin
									cur_idx <= cmd_index;
									cur_len <= cmd_len;
									cur_gen <= (cmd_op == `SFKS_OP_GEN);
									state   <= ST_HDR_OUT;
								end else begin
									cmd_error <= 1'b1;
								end
							end
							`SFKS_OP_UNWRAP: begin
								if (root_valid) begin
									state <= ST_UNW_HDR;
								end else begin
									cmd_error <= 1'b1;
								end
							end
							default: begin
								cmd_error <= 1'b1;
							end
						endcase
					end
				end
				ST_HELP_OUT: begin
					// Fresh entropy becomes the root; helper hides it under the fingerprint
					if (out_free) begin
						root_mem[cnt[2:0]] <= entropy_word;
						dout_valid         <= 1'b1;
						dout_data          <= fp_word ^ entropy_word;
						cnt                <= cnt + 8'h01;
						if (cnt == `SFKS_ROOT_LAST) begin
							root_valid <= 1'b1;
							state      <= ST_IDLE;
						end
					end
				end
				ST_HELP_IN: begin
					if (din_valid) begin
						root_mem[cnt[2:0]] <= fp_word ^ din_data;
						cnt                <= cnt + 8'h01;
						if (cnt == `SFKS_ROOT_LAST) begin
							root_valid <= 1'b1;
							state      <= ST_IDLE;
						end
					end
				end
				ST_HDR_OUT: begin
					if (out_free) begin
						dout_valid <= 1'b1;
						dout_data  <= {21'h000000, cur_len, cur_idx};
						state      <= ST_WRAP;
					end
				end
				ST_WRAP: begin
					// Each key word is mixed on the fly; only the code is ever stored
					if (out_free && wrap_have) begin
						dout_valid <= 1'b1;
						dout_data  <= wrap_src ^ mix_word;
						cnt        <= cnt + 8'h01;
						if (cnt == last_cnt) begin
							state <= ST_IDLE;
						end
					end
				end
				ST_UNW_HDR: begin
					if (din_valid) begin
						if (hdr_len_ok) begin
							cur_idx <= din_data[`SFKS_HDR_IDX_LSB +: 4];
							cur_len <= din_data[`SFKS_HDR_LEN_LSB +: 7];
							state   <= ST_UNWRAP;
						end else begin
							cmd_error <= 1'b1;
							state     <= ST_IDLE;
						end
					end
				end
				ST_UNWRAP: begin
					if (din_valid && cur_idx == 4'h0) begin
						// Hardware-only key: register port keeps reading zero
						hwkey_valid <= 1'b1;
						hwkey_data  <= din_data ^ mix_word;
						hwkey_last  <= (cnt == last_cnt);
						dout_data   <= `SFKS_RST_WORD;
						cnt         <= cnt + 8'h01;
						if (cnt == last_cnt) begin
							state <= ST_IDLE;
						end
					end else if (din_valid && out_free) begin
						dout_valid <= 1'b1;
						dout_data  <= din_data ^ mix_word;
						cnt        <= cnt + 8'h01;
						if (cnt == last_cnt) begin
							state <= ST_IDLE;
						end
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

endmodule

// File: testbench/sfks_sva.sv
`include "sfks_map.vh"
module sfks_sva(
	input        sys_clk,
	input        arst_n,
	input        cmd_valid,
	input [2:0]  cmd_op,
	input [3:0]  cmd_index,
	input [6:0]  cmd_len,
	input        cmd_ready,
	input        cmd_error,
	input        root_valid,
	input        dout_valid,
	input [31:0] dout_data,
	input        dout_ready,
	input        hwkey_valid,
	input [31:0] hwkey_data,
	input        hwkey_last
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// Taken command, key-making op, length in range
	wire tk = cmd_valid && cmd_ready;
	wire kop = cmd_op == `SFKS_OP_WRAP || cmd_op == `SFKS_OP_GEN;
	wire lok = cmd_len >= `SFKS_LEN_MIN && cmd_len <= `SFKS_LEN_MAX;
	property p_hw; hwkey_valid |-> !dout_valid && dout_data == 32'h0; endproperty
	a_hw: assert property (p_hw) else $error("leak");
	property p_hz; !hwkey_valid |-> hwkey_data == 32'h0; endproperty
	a_hz: assert property (p_hz) else $error("hw bus lit");
	property p_dz; !dout_valid |-> dout_data == 32'h0; endproperty
	a_dz: assert property (p_dz) else $error("port lit");
	property p_ln; tk && kop && !lok |=> cmd_error; endproperty
	a_ln: assert property (p_ln) else $error("bad length");
	property p_nr; tk && (kop || cmd_op == `SFKS_OP_UNWRAP) && !root_valid |=> cmd_error; endproperty
	a_nr: assert property (p_nr) else $error("no root");
	property p_cl; tk && cmd_op == `SFKS_OP_ENROLL |=> !root_valid; endproperty
	a_cl: assert property (p_cl) else $error("stale root");
	property p_hd; tk && kop && lok && root_valid |=> !cmd_error ##1 dout_valid
		&& dout_data == {21'h0, $past(cmd_len, 2), $past(cmd_index, 2)}; endproperty
	a_hd: assert property (p_hd) else $error("bad header");
	property p_st; dout_valid && !dout_ready |=> dout_valid && $stable(dout_data); endproperty
	a_st: assert property (p_st) else $error("word lost");
	c_hw: cover property (hwkey_last);
	c_er: cover property (cmd_error);
	c_rt: cover property ($rose(root_valid));
endmodule

// File: testbench/sfks_host.sv
module sfks_host(
	input  wire  sys_clk,
	output logic dout_ready = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	// Slow reader: stalls about one word in four
	always @(negedge sys_clk) dout_ready <= $urandom % 4 != 0;
endmodule

// File: testbench/tb.sv
`include "sfks_map.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic         sys_clk = 0, arst_n = 0, cmd_valid = 0, din_valid = 0;
	logic [255:0] sram_fingerprint;
	logic [31:0]  entropy_word, din_data = 0, cap[$];
	logic [2:0]   cmd_op = 0;
	logic [3:0]   cmd_index = 0;
	logic [6:0]   cmd_len = 0;
	logic [33:0]  x, exq[$];
	wire  [31:0]  dout_data, hwkey_data;
	wire          cmd_ready, cmd_error, root_valid, din_ready, dout_valid, dout_ready, hwkey_valid, hwkey_last;
	int           failures = 0, checks = 0;
	sfks_core uut(.*);
	sfks_host host(.sys_clk(sys_clk), .dout_ready(dout_ready));
	initial forever #25 sys_clk = ~sys_clk;
	task automatic chk(input logic [32:0] s, e);
		checks++;
		if (s !== e) begin
			failures++;
			$display("wrong value %0t %h %h", $time, s, e);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Held from a falling edge until taken
	task automatic cmd(input logic [2:0] op, input logic [3:0] ix, input logic [6:0] ln, input logic er);
		@(negedge sys_clk) {cmd_valid, cmd_op, cmd_index, cmd_len} = {1'b1, op, ix, ln};
		do @(posedge sys_clk); while (!cmd_ready);
		@(negedge sys_clk) cmd_valid = 0;
		chk(cmd_error, er);
	endtask
	task automatic put(input logic [31:0] w);
		@(negedge sys_clk) {din_valid, din_data} = {1'b1, w};
		do @(posedge sys_clk); while (!din_ready);
		@(negedge sys_clk) {din_valid, din_data} = {1'b0, ~w};
	endtask
	// Bounded wait until idle with all notes used
	task automatic settle;
		repeat (2) @(posedge sys_clk);
		for (int i = 0; i < 3000 && !(cmd_ready && exq.size() == 0); i++)
			@(posedge sys_clk);
		// A stuck block must not slip through to the verdict
		if (!(cmd_ready && exq.size() == 0))
			failures++;
		@(negedge sys_clk);
	endtask
	// Make a code, then feed it back and expect the key
	task automatic trip(input logic [2:0] op, input logic [3:0] ix, input logic [6:0] ln);
		logic [31:0] k[$];
		exq.push_back({2'b01, 21'h0, ln, ix});
		// Every root word equals the enrolled entropy word
		for (int i = 0; i < 2 * ln; i++) begin
			k.push_back(op == `SFKS_OP_GEN ? entropy_word : $urandom);
			exq.push_back({2'b01, k[i] ^ entropy_word ^ i});
		end
		cap.delete();
		cmd(op, ix, ln, 1'b0);
		if (op == `SFKS_OP_WRAP)
			foreach (k[i]) put(k[i]);
		settle;
		foreach (k[i]) exq.push_back({ix == 4'h0, 1'b1, k[i]});
		cmd(`SFKS_OP_UNWRAP, 4'h0, 7'h00, 1'b0);
		repeat (2 * ln + 1) put(cap.pop_front());
		settle;
	endtask
	// Oldest note against each word that leaves
	always @(posedge sys_clk) if (arst_n && (dout_valid && dout_ready || hwkey_valid)) begin
		if (dout_valid && dout_ready)
			cap.push_back(dout_data);
		if (exq.size() == 0)
			chk(33'h0, 33'h1FFFFFFFF);
		else begin
			x = exq.pop_front();
			if (x[32])
				chk({hwkey_valid, hwkey_valid ? hwkey_data : dout_data}, {x[33], x[31:0]});
			// Last hardware word is the final note of the key
			if (x[33])
				chk(hwkey_last, exq.size() == 0);
		end
	end
	initial begin
		void'($urandom(32'h0B1D1473));
		entropy_word = $urandom;
		for (int i = 0; i < 8; i++)
			sram_fingerprint[i*32 +: 32] = $urandom;
		repeat (12) @(posedge sys_clk);
		@(negedge sys_clk) arst_n = 1;
		cmd(`SFKS_OP_WRAP, 4'h1, 7'h01, 1'b1);
		cmd(3'h7, 4'h0, 7'h00, 1'b1);
		for (int i = 0; i < 8; i++)
			exq.push_back({2'b01, sram_fingerprint[i*32 +: 32] ^ entropy_word});
		cmd(`SFKS_OP_ENROLL, 4'h0, 7'h00, 1'b0);
		settle;
		chk(root_valid, 1'b1);
		// Rebuild the root from the saved helper words
		cmd(`SFKS_OP_START, 4'h0, 7'h00, 1'b0);
		repeat (8) put(cap.pop_front());
		settle;
		chk(root_valid, 1'b1);
		cmd(`SFKS_OP_WRAP, 4'h2, 7'h41, 1'b1);
		trip(`SFKS_OP_WRAP, 4'h5, `SFKS_LEN_MIN);
		trip(`SFKS_OP_WRAP, 4'h0, `SFKS_LEN_MAX);
		trip(`SFKS_OP_GEN, 4'h9, 7'h03);
		give_verdict;
	end
	// Far beyond the expected run length
	initial begin
		#500000;
		failures++;
		give_verdict;
	end
endmodule
bind sfks_core sfks_sva u_chk(.*);
